// *** design/ued_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
module ued_engine
	import ued_pkg::*;
#(
	parameter int SUSP_CYC = SUSPEND_CYC
) (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// static configuration
	input  wire logic [15:0]          ep_table_base,
	input  wire logic [NUM_EP-1:0]    pp_en,
	input  wire logic                 low_speed,
	input  wire logic [1:0]           clk_src_sel,
	output logic      [1:0]           bus_clk_sel,
	// tokens from the link layer
	input  wire logic                 tok_valid,
	output logic                      tok_ready,
	input  wire logic [1:0]           tok_pid,
	input  wire logic [3:0]           tok_ep,
	// received data packet
	input  wire logic                 rx_valid,
	output logic                      rx_ready,
	input  wire logic [7:0]           rx_data,
	input  wire logic                 rx_last,
	input  wire logic                 rx_zlp,
	input  wire logic                 rx_data1,
	// transmitted data packet
	output logic                      tx_valid,
	input  wire logic                 tx_ready,
	output logic      [7:0]           tx_data,
	output logic                      tx_last,
	output logic                      tx_zlp,
	output logic                      tx_data1,
	// handshake to send
	output logic                      hs_valid,
	output logic      [1:0]           hs_code,
	// sram dma master
	output logic                      mem_req,
	output logic                      mem_we,
	output logic      [15:0]          mem_addr,
	output logic      [7:0]           mem_wdata,
	input  wire logic                 mem_gnt,
	input  wire logic [7:0]           mem_rdata,
	// completion queue toward software
	output logic                      cq_valid,
	input  wire logic                 cq_ready,
	output logic      [4:0]           cq_data,
	// line state and power
	input  wire logic                 line_idle,
	input  wire logic                 line_se0,
	input  wire logic                 line_resume,
	output logic                      sleep_req,
	output logic                      wake_req,
	// flags and interrupt
	input  wire logic [NUM_FLAGS-1:0] flag_clr,
	input  wire logic [NUM_FLAGS-1:0] irq_en,
	output logic      [NUM_FLAGS-1:0] flags,
	output logic                      irq
);
	typedef enum logic [3:0] {
		S_IDLE, S_FETCH, S_DECIDE, S_TX, S_ZLP, S_RX, S_UPD, S_WB,
		S_HS, S_DONE
	} ued_state_t;

	ued_state_t  st;
	ued_state_t  next_st;
	logic [3:0]  ep;
	logic        dir_in;
	logic        setup;
	logic        slot;
	logic [7:0]  rec [REC_BYTES];
	logic [3:0]  idx;
	logic        rd_pend;
	logic [2:0]  rd_idx;
	logic [9:0]  off;
	logic [9:0]  sent;
	logic        wr_busy;
	logic [7:0]  wdata;
	logic [15:0] waddr;
	logic        got_last;
	logic        pid1;
	logic        drop;
	logic        ovf;
	logic        fin;
	logic [NUM_EP-1:0] bank;
	logic [NUM_EP-1:0] tog_in;
	logic [NUM_EP-1:0] tog_out;
	logic        bus_reset;
	logic        txf_in_ready;
	logic        cq_in_ready;

	// fields of the fetched endpoint record
	wire logic [1:0] ep_type = rec[REC_CTRL][1:0];
	wire logic       is_iso  = ep_type == EP_ISO;
	wire logic       stalled = rec[REC_CTRL][CTRL_STALL] && !setup;
	wire logic       armed   = rec[REC_CTRL][CTRL_ARMED];
	wire logic       multi   = rec[REC_CTRL][CTRL_MULTI];
	wire logic       refuse  = stalled || (!armed && !setup);
	wire logic [9:0] mp_raw  = {rec[REC_MPH][1:0], rec[REC_MPL]};
	wire logic       ls_cap  = low_speed && mp_raw > LS_MAXPKT;
	wire logic [9:0] maxpkt  = ls_cap ? LS_MAXPKT : mp_raw;
	wire logic [9:0] cnt     = {rec[REC_CNTH][1:0], rec[REC_CNTL]};
	wire logic [15:0] ptr    = {rec[REC_PTRH], rec[REC_PTRL]};
	wire logic [9:0] pkt     = (cnt < maxpkt) ? cnt : maxpkt;
	wire logic [9:0] rx_lim  = multi ? pkt : maxpkt;

	// outcome of the packet just moved; multi-packet keeps the endpoint
	// armed until the total is reached or the host sends a short packet
	wire logic [9:0] cnt_new = multi ? cnt - off : off;
	wire logic       final_pkt = !multi || cnt_new == 10'h000 ||
		off < maxpkt;
	wire logic       tog_cur = dir_in ? tog_in[ep] : tog_out[ep];
	wire logic       dup     = !dir_in && !setup && !is_iso &&
		pid1 != tog_cur;

	// dma address and request selection
	wire logic fetch_rq = st == S_FETCH && idx != 4'h8;
	wire logic wb_rq    = st == S_WB && idx != 4'h8;
	wire logic tx_rq    = st == S_TX && off != pkt && !rd_pend &&
		txf_in_ready;
	wire logic [15:0] rec_addr = ep_table_base +
		{8'h00, ep, slot, idx[2:0]};
	wire logic [15:0] dat_addr = ptr + {6'h00, off};
	wire logic rec_rq   = fetch_rq || wb_rq;
	wire logic mem_fire = mem_req && mem_gnt;
	wire logic tx_fire  = tx_valid && tx_ready;
	wire logic rx_fire  = rx_valid && rx_ready;
	wire logic txf_in_valid = rd_pend && st == S_TX;
	wire logic cq_in_valid  = st == S_DONE && fin;
	wire logic evt_done     = cq_in_valid && cq_in_ready;

	assign mem_req   = rec_rq || tx_rq || wr_busy;
	assign mem_we    = wb_rq || wr_busy;
	assign mem_addr  = rec_rq ? rec_addr : wr_busy ? waddr : dat_addr;
	assign mem_wdata = wr_busy ? wdata : rec[idx[2:0]];

	// link side strobes
	assign tok_ready = st == S_IDLE;
	assign rx_ready  = st == S_RX && !wr_busy && !got_last;
	assign tx_last   = tx_valid && sent == pkt - 10'h001;
	assign tx_zlp    = st == S_ZLP;
	assign tx_data1  = tog_in[ep];
	assign hs_valid  = st == S_HS && !is_iso;
	assign hs_code   = (!drop || dup) ? HS_ACK : stalled ? HS_STALL :
		setup ? HS_ACK : HS_NAK;

	// transaction sequencing
	always_comb begin
		next_st = st;
		unique case (st)
			S_IDLE:
				if (tok_valid)
					next_st = S_FETCH;
			S_FETCH:
				if (idx == 4'h8 && !rd_pend)
					next_st = S_DECIDE;
			S_DECIDE:
				if (!dir_in)
					next_st = S_RX;
				else if (refuse)
					next_st = S_HS;
				else if (pkt == 10'h000)
					next_st = S_ZLP;
				else
					next_st = S_TX;
			S_TX:
				if (tx_fire && tx_last)
					next_st = S_UPD;
			S_ZLP:
				next_st = S_UPD;
			S_RX:
				if (got_last && !wr_busy)
					next_st = (drop || dup) ? S_HS : S_UPD;
			S_UPD:
				next_st = S_WB;
			S_WB:
				if (idx == 4'h8)
					next_st = dir_in ? S_DONE : S_HS;
			S_HS:
				next_st = (drop || dup) ? S_IDLE : S_DONE;
			S_DONE:
				if (!fin || cq_in_ready)
					next_st = S_IDLE;
		endcase
	end

	// state register; a bus reset abandons any transaction in flight
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			st <= S_IDLE;
		else
			st <= bus_reset ? S_IDLE : next_st;
	end

	// token capture and buffer slot choice
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ep     <= 4'h0;
			dir_in <= 1'b0;
			setup  <= 1'b0;
			slot   <= 1'b0;
		end else if (st == S_IDLE && tok_valid) begin
			ep     <= tok_ep;
			dir_in <= tok_pid == TOK_IN;
			setup  <= tok_pid == TOK_SETUP;
			slot   <= pp_en[tok_ep] ? bank[tok_ep] :
				tok_pid == TOK_IN;
		end
	end

	// record index and read pipeline; sram data arrives one cycle late
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			idx     <= 4'h0;
			rd_pend <= 1'b0;
			rd_idx  <= 3'h0;
		end else begin
			if (st == S_IDLE || st == S_UPD)
				idx <= 4'h0;
			else if (rec_rq && mem_gnt)
				idx <= idx + 4'h1;
			rd_pend <= mem_fire && !mem_we && !bus_reset;
			rd_idx  <= idx[2:0];
		end
	end

	// endpoint record copy: filled by the fetch, updated before write-back
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < REC_BYTES; i++)
				rec[i] <= REC_RST;
			fin <= 1'b0;
		end else if (st == S_FETCH && rd_pend) begin
			rec[rd_idx] <= mem_rdata;
		end else if (st == S_UPD) begin
			rec[REC_CNTL] <= cnt_new[7:0];
			rec[REC_CNTH] <= {6'h00, cnt_new[9:8]};
			rec[REC_PTRL] <= multi ? dat_addr[7:0] : ptr[7:0];
			rec[REC_PTRH] <= multi ? dat_addr[15:8] : ptr[15:8];
			rec[REC_CTRL][CTRL_ARMED] <= !final_pkt;
			rec[REC_STAT] <= {4'h0, ovf, slot, setup, final_pkt};
			fin <= final_pkt;
		end
	end

	// byte counters for the data phase
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			off  <= 10'h000;
			sent <= 10'h000;
		end else if (st == S_DECIDE) begin
			off  <= 10'h000;
			sent <= 10'h000;
		end else begin
			if ((tx_rq && mem_gnt) || (rx_fire && !drop && off < rx_lim))
				off <= off + 10'h001;
			if (tx_fire)
				sent <= sent + 10'h001;
		end
	end

	// receive path: one byte held at a time while it is written to sram;
	// bytes past the payload limit are counted as overflow, not written
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_busy  <= 1'b0;
			wdata    <= 8'h00;
			waddr    <= 16'h0000;
			got_last <= 1'b0;
			pid1     <= 1'b0;
			drop     <= 1'b0;
			ovf      <= 1'b0;
		end else if (bus_reset || st == S_DECIDE) begin
			wr_busy  <= 1'b0;
			got_last <= 1'b0;
			drop     <= refuse || (setup && !armed);
			ovf      <= 1'b0;
		end else begin
			if (rx_fire && !drop && off < rx_lim) begin
				wr_busy <= 1'b1;
				wdata   <= rx_data;
				waddr   <= dat_addr;
			end else if (mem_gnt) begin
				wr_busy <= 1'b0;
			end
			if (rx_fire && !drop && off >= rx_lim)
				ovf <= 1'b1;
			if ((rx_fire && rx_last) || (st == S_RX && rx_zlp)) begin
				got_last <= 1'b1;
				pid1     <= rx_data1;
			end
		end
	end

	// per-address bank and data toggle state
	for (genvar g = 0; g < NUM_EP; g++) begin : g_ep
		wire logic here = ep == 4'(g) && st == S_DONE &&
			next_st == S_IDLE;
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				bank[g]    <= 1'b0;
				tog_in[g]  <= 1'b0;
				tog_out[g] <= 1'b0;
			end else if (bus_reset) begin
				bank[g]    <= 1'b0;
				tog_in[g]  <= 1'b0;
				tog_out[g] <= 1'b0;
			end else if (here) begin
				// swap buffers so software owns the one just used
				if (pp_en[g])
					bank[g] <= ~bank[g];
				// a setup restarts both directions on data1
				if (setup) begin
					tog_in[g]  <= 1'b1;
					tog_out[g] <= 1'b1;
				end else if (dir_in) begin
					tog_in[g]  <= ~tog_in[g];
				end else begin
					tog_out[g] <= ~tog_out[g];
				end
			end
		end
	end

	// clock source choice is passed to the clock mux outside this block
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			bus_clk_sel <= 2'h0;
		else
			bus_clk_sel <= clk_src_sel;
	end

	// transmit data buffer between the dma reads and the link
	ued_fifo #(
		.W(8),
		.D(FIFO_DEPTH)
	) u_txf (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  (txf_in_valid),
		.in_ready  (txf_in_ready),
		.in_data   (mem_rdata),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (tx_data)
	);

	// completion queue; a full queue stalls the engine in its last state
	ued_fifo #(
		.W(5),
		.D(FIFO_DEPTH)
	) u_cq (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.in_valid  (cq_in_valid),
		.in_ready  (cq_in_ready),
		.in_data   ({dir_in, ep}),
		.out_valid (cq_valid),
		.out_ready (cq_ready),
		.out_data  (cq_data)
	);

	// suspend, resume, bus reset and status flags
	ued_power #(
		.SUSP_CYC(SUSP_CYC)
	) u_pwr (
		.core_clk    (core_clk),
		.rst_n       (rst_n),
		.line_idle   (line_idle),
		.line_se0    (line_se0),
		.line_resume (line_resume),
		.evt_done    (evt_done),
		.flag_clr    (flag_clr),
		.irq_en      (irq_en),
		.flags       (flags),
		.irq         (irq),
		.sleep_req   (sleep_req),
		.wake_req    (wake_req),
		.bus_reset   (bus_reset)
	);
endmodule
`default_nettype wire

// *** design/ued_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module ued_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   fill;

	// depth must be a power of two so the pointers wrap by themselves
	wire logic push = in_valid && in_ready;
	wire logic pop  = out_valid && out_ready;
	assign in_ready  = fill != (AW+1)'(D);
	assign out_valid = fill != '0;
	assign out_data  = mem[rd_ptr];

	// storage
	always_ff @(posedge core_clk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// pointers and fill level
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end else begin
			wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
			rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
			fill   <= fill + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// *** design/ued_pkg.sv ***
package ued_pkg;

	// timing, in the units they are specified in, then as cycle counts
	localparam int CLK_MHZ     = 100;
	localparam int SUSPEND_US  = 3000;
	localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
	localparam int RESET_NS    = 2500;
	localparam int RESET_CYC   = (RESET_NS * CLK_MHZ + 999) / 1000;

	// sizes
	localparam int NUM_EP     = 16;
	localparam int REC_BYTES  = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int NUM_FLAGS  = 4;

	// byte offsets inside one endpoint record in sram
	localparam logic [2:0] REC_CTRL = 3'h0;
	localparam logic [2:0] REC_MPL  = 3'h1;
	localparam logic [2:0] REC_MPH  = 3'h2;
	localparam logic [2:0] REC_CNTL = 3'h3;
	localparam logic [2:0] REC_CNTH = 3'h4;
	localparam logic [2:0] REC_PTRL = 3'h5;
	localparam logic [2:0] REC_PTRH = 3'h6;
	localparam logic [2:0] REC_STAT = 3'h7;
	localparam logic [7:0] REC_RST  = 8'h00;

	// control byte fields (type sits in bits 1:0)
	localparam int CTRL_STALL = 2;
	localparam int CTRL_MULTI = 4;
	localparam int CTRL_ARMED = 5;

	// status byte fields written back after each accepted transaction
	localparam int STAT_DONE  = 0;
	localparam int STAT_SETUP = 1;
	localparam int STAT_BANK  = 2;
	localparam int STAT_OVF   = 3;

	// endpoint transfer types
	localparam logic [1:0] EP_CTRL = 2'h0;
	localparam logic [1:0] EP_INTR = 2'h1;
	localparam logic [1:0] EP_BULK = 2'h2;
	localparam logic [1:0] EP_ISO  = 2'h3;

	// token kinds from the link layer
	localparam logic [1:0] TOK_OUT   = 2'h0;
	localparam logic [1:0] TOK_IN    = 2'h1;
	localparam logic [1:0] TOK_SETUP = 2'h2;

	// handshake codes toward the link layer
	localparam logic [1:0] HS_ACK   = 2'h0;
	localparam logic [1:0] HS_NAK   = 2'h1;
	localparam logic [1:0] HS_STALL = 2'h2;

	// status flag positions
	localparam int FLAG_DONE   = 0;
	localparam int FLAG_SUSP   = 1;
	localparam int FLAG_RESUME = 2;
	localparam int FLAG_RESET  = 3;

	// payload limits
	localparam logic [9:0] LS_MAXPKT = 10'h008;

endpackage

// *** design/ued_power.sv ***
`timescale 1ns/1ps
`default_nettype none
module ued_power
	import ued_pkg::*;
#(
	parameter int SUSP_CYC = SUSPEND_CYC
) (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// line state from the transceiver
	input  wire logic                 line_idle,
	input  wire logic                 line_se0,
	input  wire logic                 line_resume,
	// engine event
	input  wire logic                 evt_done,
	// flag service
	input  wire logic [NUM_FLAGS-1:0] flag_clr,
	input  wire logic [NUM_FLAGS-1:0] irq_en,
	output logic      [NUM_FLAGS-1:0] flags,
	output logic                      irq,
	// power and reset outputs
	output logic                      sleep_req,
	output logic                      wake_req,
	output logic                      bus_reset
);
	localparam int IW = $clog2(SUSP_CYC + 1);
	localparam int RW = $clog2(RESET_CYC + 1);

	logic [IW-1:0] idle_cnt;
	logic [RW-1:0] se0_cnt;
	logic          rst_seen;

	// event detection; each long condition fires once per occurrence
	wire logic susp_hit   = line_idle && !sleep_req &&
		idle_cnt == IW'(SUSP_CYC - 1);
	wire logic rst_hit    = line_se0 && !rst_seen &&
		se0_cnt == RW'(RESET_CYC - 1);
	wire logic resume_hit = sleep_req && line_resume;
	wire logic [NUM_FLAGS-1:0] evt = {rst_hit, resume_hit, susp_hit,
		evt_done};

	assign irq = |(flags & irq_en);

	// idle and se0 duration counters
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_cnt <= '0;
			se0_cnt  <= '0;
			rst_seen <= 1'b0;
		end else begin
			idle_cnt <= (!line_idle || sleep_req) ? '0 :
				susp_hit ? idle_cnt : idle_cnt + 1'b1;
			se0_cnt  <= (!line_se0 || rst_seen) ? '0 : se0_cnt + 1'b1;
			rst_seen <= line_se0 && (rst_seen || rst_hit);
		end
	end

	// suspend holds sleep until the line leaves idle; wake follows each resume cycle one cycle later
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_req <= 1'b0;
			wake_req  <= 1'b0;
			bus_reset <= 1'b0;
		end else begin
			sleep_req <= susp_hit || (sleep_req && line_idle);
			wake_req  <= resume_hit;
			bus_reset <= rst_hit;
		end
	end

	// sticky flags, a new event beats a clear in the same cycle
	for (genvar g = 0; g < NUM_FLAGS; g++) begin : g_flag
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n)
				flags[g] <= 1'b0;
			else
				flags[g] <= evt[g] || (flags[g] && !flag_clr[g]);
		end
	end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench
	import ued_pkg::*;
;
	localparam int SC = 40;
	logic core_clk = 1'h0, rst_n = 1'h0, low_speed = 1'h0;
	logic [15:0] ep_table_base = 16'h0100, mem_addr;
	logic [NUM_EP-1:0] pp_en = '0;
	logic [1:0] clk_src_sel = 2'h0, bus_clk_sel, tok_pid, hs_code, hs_seen;
	logic [1:0] pid = 2'h0;
	logic [3:0] tok_ep, ep = 4'h0, n = 4'h0;
	logic [7:0] rx_data, tx_data, mem_wdata, mem_rdata = 8'h00;
	logic tok_valid, tok_ready, rx_valid, rx_ready, rx_last, rx_zlp;
	logic rx_data1, tx_valid, tx_ready, tx_last, tx_zlp, tx_data1;
	logic hs_valid, mem_req, mem_we, mem_gnt, cq_valid, sleep_req;
	logic wake_req, irq, cq_ready = 1'h0, woke = 1'h0;
	logic line_idle = 1'h0, line_se0 = 1'h0, line_resume = 1'h0;
	logic go = 1'h0, slow = 1'h0, ph = 1'h0;
	logic [4:0] cq_data;
	logic [NUM_FLAGS-1:0] flag_clr = '0, irq_en = '0, flags;
	logic [7:0] sram [0:1023];
	logic [7:0] txq [$];
	int fails = 0, n_checks = 0, cyc = 0, ends = 0;

	ued_engine #(.SUSP_CYC(SC)) ued_engine_i (.*);
	ued_host ued_host_i (.*);

	always #5 core_clk = ~core_clk;
	// sram answers one cycle after the grant; slow mode grants every other
	assign mem_gnt = mem_req && (!slow || ph);
	always @(posedge core_clk) begin
		ph <= ~ph;
		cyc <= cyc + 1;
		if (mem_req && mem_gnt && mem_we) sram[mem_addr[9:0]] <= mem_wdata;
		mem_rdata <= (mem_req && mem_gnt) ? sram[mem_addr[9:0]] : ~mem_rdata;
		if (tx_valid && tx_ready) txq.push_back(tx_data);
		if (hs_valid) hs_seen <= hs_code;
		if (wake_req) woke <= 1'h1;
		// packets ended toward the host, with data or zero-length
		if (tx_zlp || (tx_valid && tx_ready && tx_last)) ends <= ends + 1;
		if (cyc == 20000) begin
			fails++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	// record: max payload 64, data pointer 0x02pp
	task automatic rec(input logic [3:0] e, input logic s,
		input logic [7:0] c, input logic [7:0] cnt, input logic [7:0] p);
		logic [9:0] a;
		a = 10'h100 + {2'h0, e, s, 3'h0};
		for (int b = 0; b < 8; b++) sram[a + 10'(b)] = 8'h00;
		sram[a] = c;
		sram[a + 10'h1] = 8'h40;
		sram[a + 10'h3] = cnt;
		sram[a + 10'h5] = p;
		sram[a + 10'h6] = 8'h02;
	endtask
	// one transaction, back in idle with its flags settled
	task automatic xact(input logic [1:0] p, input logic [3:0] e,
		input logic [3:0] k);
		pid = p;
		ep = e;
		n = k;
		hs_seen = 2'h3;
		go = 1'h1;
		tick(1);
		go = 1'h0;
		tick(2);
		for (int w = 0; w < 400 && tok_ready !== 1'h1; w++) tick(1);
		chk(tok_ready, 1'h1);
		tick(2);
	endtask
	task automatic pop;
		cq_ready = 1'h1;
		tick(1);
		cq_ready = 1'h0;
	endtask

	task automatic t_reset;
		chk(tok_ready, 1'h1);
		chk(flags, 4'h0);
		chk(bus_clk_sel, 2'h0);
		clk_src_sel = 2'h2;
		tick(1);
		chk(bus_clk_sel, 2'h2);
	endtask
	// OUT then a slow-host IN; the queue must keep arrival order
	task automatic t_xfer;
		rec(4'h5, 1'h0, 8'h22, 8'h40, 8'h80);
		xact(TOK_OUT, 4'h5, 4'h2);
		chk(hs_seen, HS_ACK);
		chk(sram[10'h280], 8'hA0);
		chk(sram[10'h281], 8'hA1);
		chk(sram[10'h153], 8'h02);
		rec(4'h3, 1'h1, 8'h22, 8'h03, 8'h00);
		for (int b = 0; b < 3; b++) sram[10'h200 + 10'(b)] = 8'(17 * (b + 1));
		slow = 1'h1;
		irq_en = 4'h1;
		txq.delete();
		xact(TOK_IN, 4'h3, 4'h0);
		slow = 1'h0;
		chk(16'(txq.size()), 16'h3);
		for (int b = 0; b < 3; b++) chk(txq[b], 8'(17 * (b + 1)));
		chk(sram[10'h138][CTRL_ARMED], 1'h0);
		chk(flags[FLAG_DONE], 1'h1);
		chk(irq, 1'h1);
		chk(cq_data, 5'h05);
		pop();
		chk(cq_data, 5'h13);
		pop();
		chk(cq_valid, 1'h0);
		flag_clr = 4'hF;
		tick(1);
		flag_clr = 4'h0;
	endtask
	// unarmed, stalled, setup and isochronous handshakes
	task automatic t_hs;
		logic [7:0] c [4] = '{8'h02, 8'h06, 8'h00, 8'h23};
		logic [1:0] p [4] = '{TOK_OUT, TOK_OUT, TOK_SETUP, TOK_OUT};
		logic [1:0] h [4] = '{HS_NAK, HS_STALL, HS_ACK, 2'h3};
		for (int k = 0; k < 4; k++) begin
			rec(4'(6 + k), 1'h0, c[k], 8'h01, 8'hC0);
			xact(p[k], 4'(6 + k), 4'h1);
			chk(hs_seen, h[k]);
		end
		chk(sram[10'h2C0], 8'hA0);
		chk(cq_data, 5'h09);
		pop();
	endtask
	// multi-packet IN at low speed: ten bytes leave as eight then two
	task automatic t_multi;
		rec(4'hA, 1'h1, 8'h32, 8'h0A, 8'h40);
		for (int b = 0; b < 10; b++) sram[10'h240 + 10'(b)] = 8'(b + 1);
		low_speed = 1'h1;
		txq.delete();
		xact(TOK_IN, 4'hA, 4'h0);
		chk(16'(txq.size()), 16'h8);
		chk(sram[10'h1AB], 8'h02);
		chk(sram[10'h1AD], 8'h48);
		chk(cq_valid, 1'h0);
		chk(tx_data1, 1'h1);
		xact(TOK_IN, 4'hA, 4'h0);
		low_speed = 1'h0;
		chk(16'(txq.size()), 16'hA);
		for (int b = 0; b < 10; b++) chk(txq[b], 8'(b + 1));
		chk(sram[10'h1A8][CTRL_ARMED], 1'h0);
		chk(cq_data, 5'h1A);
		pop();
	endtask
	// ping-pong IN: the banks alternate, then bank 0 sends an empty packet
	task automatic t_pp;
		pp_en = 16'h0800;
		rec(4'hB, 1'h0, 8'h22, 8'h01, 8'h50);
		rec(4'hB, 1'h1, 8'h22, 8'h01, 8'h60);
		sram[10'h250] = 8'h5A;
		sram[10'h260] = 8'h6B;
		txq.delete();
		xact(TOK_IN, 4'hB, 4'h0);
		xact(TOK_IN, 4'hB, 4'h0);
		chk(txq[0], 8'h5A);
		chk(txq[1], 8'h6B);
		chk(sram[10'h1B7], 8'h01);
		chk(sram[10'h1BF], 8'h05);
		chk(16'(ends), 16'h5);
		rec(4'hB, 1'h0, 8'h22, 8'h00, 8'h50);
		xact(TOK_IN, 4'hB, 4'h0);
		chk(16'(ends), 16'h6);
		for (int q = 0; q < 3; q++) begin
			chk(cq_data, 5'h1B);
			pop();
		end
		pp_en = '0;
	endtask
	task automatic t_susp;
		line_idle = 1'h1;
		tick(SC + 3);
		chk(sleep_req, 1'h1);
		chk(flags[FLAG_SUSP], 1'h1);
		line_resume = 1'h1;
		tick(1);
		line_resume = 1'h0;
		tick(2);
		chk(woke, 1'h1);
		chk(flags[FLAG_RESUME], 1'h1);
		line_idle = 1'h0;
		tick(2);
		chk(sleep_req, 1'h0);
	endtask
	task automatic t_busrst;
		line_se0 = 1'h1;
		tick(RESET_CYC + 3);
		line_se0 = 1'h0;
		tick(2);
		chk(flags[FLAG_RESET], 1'h1);
		chk(tok_ready, 1'h1);
	endtask

	task automatic report_and_stop;
		if (fails == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		tick(16);
		rst_n = 1'h1;
		tick(1);
		t_reset();
		t_xfer();
		t_hs();
		t_multi();
		t_pp();
		t_susp();
		t_busrst();
		report_and_stop();
	end
endmodule
`default_nettype wire

// *** verification/ued_engine_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module ued_engine_chk
	import ued_pkg::*;
#(
	parameter int SUSP_CYC = SUSPEND_CYC
) (
	// clock and reset
	input wire logic                 core_clk,
	input wire logic                 rst_n,
	// watched ports
	input wire logic [1:0]           clk_src_sel,
	input wire logic [1:0]           bus_clk_sel,
	input wire logic                 tok_valid,
	input wire logic                 tok_ready,
	input wire logic                 hs_valid,
	input wire logic                 mem_req,
	input wire logic                 mem_gnt,
	input wire logic [15:0]          mem_addr,
	input wire logic                 line_idle,
	input wire logic                 line_se0,
	input wire logic                 line_resume,
	input wire logic                 sleep_req,
	input wire logic                 wake_req,
	input wire logic [NUM_FLAGS-1:0] flags,
	input wire logic [NUM_FLAGS-1:0] irq_en,
	input wire logic                 irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	logic [19:0] idle_n;
	logic [19:0] se0_n;

	// run lengths of idle and se0; saturate so a long idle never wraps
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_n <= '0;
			se0_n  <= '0;
		end else begin
			idle_n <= !line_idle ? '0 : idle_n + {19'h0, ~&idle_n};
			se0_n  <= !line_se0 ? '0 : se0_n + {19'h0, ~&se0_n};
		end
	end

	property p_clk_sel;
		$past(rst_n) |-> bus_clk_sel == $past(clk_src_sel);
	endproperty
	a_clk_sel: assert property (p_clk_sel) else $error("clock select lag");
	property p_hs_pulse;
		hs_valid |=> !hs_valid;
	endproperty
	a_hs_pulse: assert property (p_hs_pulse) else $error("handshake long");
	property p_take;
		tok_valid && tok_ready |=> !tok_ready;
	endproperty
	a_take: assert property (p_take) else $error("token not taken");
	property p_irq;
		irq == |(flags & irq_en);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");
	property p_mem_hold;
		mem_req && !mem_gnt |=> mem_req && $stable(mem_addr);
	endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("dma dropped");
	property p_susp;
		idle_n == SUSP_CYC + 2 |-> sleep_req && flags[FLAG_SUSP];
	endproperty
	a_susp: assert property (p_susp) else $error("no sleep request");
	property p_sleep_drop;
		sleep_req && !line_idle |=> !sleep_req;
	endproperty
	a_sleep_drop: assert property (p_sleep_drop) else $error("sleep held");
	property p_wake;
		wake_req |-> $past(sleep_req) && $past(line_resume) ##1 !wake_req;
	endproperty
	a_wake: assert property (p_wake) else $error("bad wake request");
	property p_bus_rst;
		se0_n == RESET_CYC + 2 |-> flags[FLAG_RESET];
	endproperty
	a_bus_rst: assert property (p_bus_rst) else $error("no bus reset");
endmodule
bind ued_engine ued_engine_chk #(.SUSP_CYC(SUSP_CYC)) ued_engine_chk_i (.*);
`default_nettype wire

// *** verification/ued_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module ued_host
	import ued_pkg::*;
(
	// commands from the bench
	input  wire logic       core_clk,
	input  wire logic       go,
	input  wire logic       slow,
	input  wire logic [1:0] pid,
	input  wire logic [3:0] ep,
	input  wire logic [3:0] n,
	// link side of the engine
	output logic            tok_valid,
	input  wire logic       tok_ready,
	output logic [1:0]      tok_pid,
	output logic [3:0]      tok_ep,
	output logic            rx_valid,
	input  wire logic       rx_ready,
	output logic [7:0]      rx_data,
	output logic            rx_last,
	output logic            rx_zlp,
	output logic            rx_data1,
	output logic            tx_ready
);
	logic [3:0] i;
	logic       ph;

	initial begin
		tok_valid = 1'h0;
		tok_pid = 2'h3;
		tok_ep = 4'h0;
		rx_valid = 1'h0;
		i = 4'h0;
		ph = 1'h0;
	end
	// idle data lines change pattern so a stale byte cannot pass
	assign rx_data  = rx_valid ? {4'hA, i} : {4'h5, ~i};
	assign rx_last  = rx_valid && (i == n - 4'h1);
	assign rx_zlp   = 1'h0;
	assign rx_data1 = 1'h0;
	// a slow host takes a byte only every other cycle
	assign tx_ready = !slow || ph;
	// token held until taken, then the data packet for OUT and SETUP
	always @(posedge core_clk) begin
		ph <= ~ph;
		if (go) begin
			tok_valid <= 1'h1;
			tok_pid <= pid;
			tok_ep <= ep;
			rx_valid <= 1'h0;
			i <= 4'h0;
		end else if (tok_valid && tok_ready) begin
			tok_valid <= 1'h0;
			tok_pid <= ~pid;
			rx_valid <= (pid != TOK_IN) && (n != 4'h0);
		end else if (rx_valid && rx_ready) begin
			i <= i + 4'h1;
			if (rx_last) rx_valid <= 1'h0;
		end
	end
endmodule
`default_nettype wire
